/* src/bawd_consts.svh */
// Constants for the bus area decoder and width selector.
// Assumes inclusion by bare name from the design files under src/.
`ifndef BAWD_CONSTS_SVH
`define BAWD_CONSTS_SVH
// Position of the area field in the physical address.
`define BAWD_AREA_HI 28
`define BAWD_AREA_LO 26
// Bit that splits a card area into memory and I/O halves.
`define BAWD_HALF_BIT 25
// Top bit of the physical address; the bits above the area field are never decoded.
`define BAWD_ADDR_MSB 31
// Area numbers.
`define BAWD_AREA0 3'h0
`define BAWD_AREA1 3'h1
`define BAWD_AREA2 3'h2
`define BAWD_AREA3 3'h3
`define BAWD_AREA4 3'h4
`define BAWD_AREA5 3'h5
`define BAWD_AREA6 3'h6
`define BAWD_AREA7 3'h7
// Width codes, shared by the straps and the per-area configuration.
`define BAWD_W_RSVD 2'h0
`define BAWD_W8 2'h1
`define BAWD_W16 2'h2
`define BAWD_W32 2'h3
// Reset value of the latched area 0 width.
`define BAWD_W_RESET 2'h3
// Chip select vectors: one bit to shift into place, nothing selected, all pins idle high.
`define BAWD_CS_ONE 7'h01
`define BAWD_CS_CLEAR 7'h00
`define BAWD_CSN_IDLE 7'h7f
`endif

/* src/bawd_pkg.sv */
// Types for the bus area decoder and width selector.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package bawd_pkg;
  // Interface kind attached to an area.
  typedef enum logic [1:0] {
    BAWD_IF_NORMAL,
    BAWD_IF_BURST,
    BAWD_IF_SDRAM,
    BAWD_IF_CARD
  } bawd_if_t;
  // Strap capture state.
  typedef enum logic {
    BAWD_ST_SAMPLE,
    BAWD_ST_RUN
  } bawd_state_t;
endpackage
`default_nettype wire

/* src/bawd_top.sv */
// Area decoder, bus width select and card space split for the external bus.
// Assumes a synchronous physical address, strobes and config bits on ref_clk.
// Rules for this block, its board, its bus master and its configuration
// R1 - Latch area 0 width from straps at reset
// R2 - Board never straps both width pins low
// R3 - Areas 2 to 6 width from config
// R4 - SDRAM areas use 16 or 32 bits
// R5 - Card areas use 8 or 16 bits
// R6 - SDRAM in areas 2 and 3 match
// R7 - Port function limits widths to 8/16
// R8 - Area from address bits 28 to 26
// R9 - Ignore address bits 31 to 29
// R10 - Areas 0 to 4 are 64 MB
// R11 - Area 7 is internal, never external
// R12 - Master avoids area 7 shadow ranges
// R13 - Area 1 registers reached via 101 prefix
// R14 - Card interface only in areas 5, 6
// R15 - Card memory low half, I/O upper
// R16 - Dynamic card I/O sizing only little-endian
// R17 - Accept card access from any region
// R18 - Card select plus high byte enables
// R19 - Card strobes follow read, write strobes
`include "bawd_consts.svh"
`default_nettype none
module bawd_top (
  input  wire logic        ref_clk,                // Bus clock.
  input  wire logic        rst,                    // Asynchronous reset, high.
  input  wire logic        area0_width_strap_high, // Area 0 width strap, upper pin.
  input  wire logic        area0_width_strap_low,  // Area 0 width strap, lower pin.
  input  wire logic [13:0] area_width_config_reg,  // Width codes, two bits per area 0..6.
  input  wire logic        area5_card,             // Area 5 holds a card interface.
  input  wire logic        area6_card,             // Area 6 holds a card interface.
  input  wire logic        area2_sdram,            // Area 2 holds SDRAM.
  input  wire logic        area3_sdram,            // Area 3 holds SDRAM.
  input  wire logic        port_func_en,           // General-purpose port in use.
  input  wire logic        little_endian,          // Little-endian mode.
  input  wire logic        io_is16,                // Card reports a 16-bit I/O port.
  input  wire logic [31:0] phys_addr,              // Physical address of access.
  input  wire logic        acc_valid,              // Access in progress.
  input  wire logic        acc_rd,                 // Read strobe of the access.
  input  wire logic        acc_wr,                 // Write strobe of the access.
  input  wire logic [1:0]  acc_bytes,              // Byte lanes, bit 1 high byte.
  output logic [2:0]       area_r,                 // Decoded area.
  output logic [1:0]       width_r,                // Width code of access.
  output logic             ext_sel_r,              // Access goes to external memory.
  output logic             internal_sel_r,         // Access goes to on-chip I/O.
  output logic [6:0]       cs_n_r,                 // Chip selects, low active, per area.
  output logic             card_io_r,              // Card access is in I/O half.
  output logic             card_a_low_byte_enable_n_r,  // Card A low enable.
  output logic             card_a_high_byte_enable_n_r, // Card A high enable.
  output logic             card_b_low_byte_enable_n_r,  // Card B low enable.
  output logic             card_b_high_byte_enable_n_r, // Card B high enable.
  output logic             card_oe_n_r,            // Card output enable.
  output logic             card_we_n_r,            // Card write enable.
  output logic [1:0]       area0_width_r,          // Latched area 0 width.
  output logic             cfg_error_r             // Configuration breaks a width limit.
);

  // Width code for one area from the packed configuration word.
  // Area 7 has no field in the word, so it reports the reserved code rather than
  // reading past the top of the vector.
  function automatic logic [1:0] cfg_width(input logic [13:0] cfg, input logic [2:0] a);
    if (a == `BAWD_AREA7) begin
      cfg_width = `BAWD_W_RSVD;
    end else begin
      cfg_width = cfg[{a, 1'b0} +: 2];
    end
  endfunction

  bawd_pkg::bawd_state_t state_r; // Strap capture state.

  // Address decode; the upper three bits never enter the decode.
  wire logic [2:0] area_w = phys_addr[`BAWD_AREA_HI:`BAWD_AREA_LO]; // R8 R9
  wire logic       is_int = (area_w == `BAWD_AREA7) || (area_w == `BAWD_AREA1); // R11
  wire logic       is_card5 = (area_w == `BAWD_AREA5) && area5_card; // R14
  wire logic       is_card6 = (area_w == `BAWD_AREA6) && area6_card; // R14 R17
  wire logic       is_card = is_card5 || is_card6;
  wire logic       io_half = phys_addr[`BAWD_HALF_BIT]; // R15
  // Card I/O width follows the card only in little-endian mode.
  wire logic       dyn_size = is_card && io_half && little_endian; // R16
  wire logic [1:0] base_w = (area_w == `BAWD_AREA0) ? area0_width_r
                          : cfg_width(area_width_config_reg, area_w); // R3
  wire logic [1:0] dyn_w = io_is16 ? `BAWD_W16 : `BAWD_W8;
  wire logic [1:0] width_w = dyn_size ? dyn_w : base_w;
  // Chip select vector, one bit per external area; areas 1 and 7 never select.
  wire logic [6:0] cs_w = (acc_valid && !is_int) ? (`BAWD_CS_ONE << area_w) // R10
                                                 : `BAWD_CS_CLEAR;
  wire logic       ce_lo = acc_valid && acc_bytes[0];
  wire logic       ce_hi = acc_valid && acc_bytes[1];
  // Width limit checks reported to software; the block does not police them.
  wire logic [1:0] w2 = cfg_width(area_width_config_reg, `BAWD_AREA2);
  wire logic [1:0] w3 = cfg_width(area_width_config_reg, `BAWD_AREA3);
  // Area 4 width, read only by the chk_cfg_width assertion and not by the limit check.
  wire logic [1:0] w4 = cfg_width(area_width_config_reg, `BAWD_AREA4);
  wire logic [1:0] w5 = cfg_width(area_width_config_reg, `BAWD_AREA5);
  wire logic [1:0] w6 = cfg_width(area_width_config_reg, `BAWD_AREA6);
  wire logic       err_w = (area2_sdram && w2 == `BAWD_W8) || (area3_sdram && w3 == `BAWD_W8)
                         || (area5_card && w5 == `BAWD_W32) || (area6_card && w6 == `BAWD_W32)
                         || (area2_sdram && area3_sdram && w2 != w3)
                         || (port_func_en && (w2 == `BAWD_W32 || w3 == `BAWD_W32));

  // Strap capture: the first clocked edge after release takes the area 0 width.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r       <= bawd_pkg::BAWD_ST_SAMPLE;
      area0_width_r <= `BAWD_W_RESET;
    end else begin
      unique case (state_r)
        // First edge after release; the board keeps the pattern off both-low.
        bawd_pkg::BAWD_ST_SAMPLE: begin
          area0_width_r <= {area0_width_strap_high, area0_width_strap_low}; // R1 R2
          state_r       <= bawd_pkg::BAWD_ST_RUN;
        end
        // Running: the latched width holds until the next reset.
        bawd_pkg::BAWD_ST_RUN: begin
          area0_width_r <= area0_width_r;
          state_r       <= bawd_pkg::BAWD_ST_RUN;
        end
      endcase
    end
  end

  // Registered decode outputs.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      area_r         <= `BAWD_AREA0;
      width_r        <= `BAWD_W_RESET;
      ext_sel_r      <= 1'b0;
      internal_sel_r <= 1'b0;
      cs_n_r         <= `BAWD_CSN_IDLE;
      card_io_r      <= 1'b0;
      cfg_error_r    <= 1'b0;
    end else begin
      area_r         <= area_w;
      width_r        <= width_w;
      ext_sel_r      <= acc_valid && !is_int; // R11
      internal_sel_r <= acc_valid && is_int;
      cs_n_r         <= ~cs_w; // R18
      card_io_r      <= is_card && io_half; // R15
      cfg_error_r    <= err_w; // R4 R5 R6 R7
    end
  end

  // Card strobes: enables for bytes, output and write enables from strobes.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      card_a_low_byte_enable_n_r  <= 1'b1;
      card_a_high_byte_enable_n_r <= 1'b1;
      card_b_low_byte_enable_n_r  <= 1'b1;
      card_b_high_byte_enable_n_r <= 1'b1;
      card_oe_n_r                 <= 1'b1;
      card_we_n_r                 <= 1'b1;
    end else begin
      card_a_low_byte_enable_n_r  <= !(is_card5 && ce_lo); // R19
      card_a_high_byte_enable_n_r <= !(is_card5 && ce_hi); // R18
      card_b_low_byte_enable_n_r  <= !(is_card6 && ce_lo); // R19
      card_b_high_byte_enable_n_r <= !(is_card6 && ce_hi); // R18
      card_oe_n_r                 <= !(is_card && acc_valid && acc_rd); // R19
      card_we_n_r                 <= !(is_card && acc_valid && acc_wr); // R19
    end
  end

  // Access shapes that several checks below start from.
  sequence s_card_access;
    acc_valid && is_card;
  endsequence
  sequence s_area0_access;
    acc_valid && (area_w == `BAWD_AREA0);
  endsequence
  sequence s_internal_access;
    acc_valid && is_int;
  endsequence

  // The decoded area is the address field of the cycle before.
  chk_area_decode: assert property (@(posedge ref_clk) disable iff (rst) // R8
    1'b1 |=> area_r == $past(area_w)) else $error("area decode wrong");
  // Moving only the upper three bits leaves the area where it was.
  chk_shadow_ignore: assert property (@(posedge ref_clk) disable iff (rst) // R9
    $stable(phys_addr[`BAWD_AREA_HI:0])
    && $changed(phys_addr[`BAWD_ADDR_MSB:`BAWD_AREA_HI+1]) |=> $stable(area_r))
    else $error("upper bits changed area");
  // Area 7 stays on chip: no external select and every chip select idle.
  chk_area7_internal: assert property (@(posedge ref_clk) disable iff (rst) // R11
    acc_valid && area_w == `BAWD_AREA7 |=> !ext_sel_r && cs_n_r == `BAWD_CSN_IDLE)
    else $error("area 7 went external");
  // An area 4 access lowers exactly the area 4 chip select.
  chk_cs_onehot: assert property (@(posedge ref_clk) disable iff (rst) // R10
    acc_valid && area_w == `BAWD_AREA4 |=> cs_n_r == ~(`BAWD_CS_ONE << `BAWD_AREA4))
    else $error("cs4 wrong");
  // Below area 5 the card output and write enables stay idle and no I/O half is flagged.
  chk_card_only56: assert property (@(posedge ref_clk) disable iff (rst) // R14
    area_w < `BAWD_AREA5 |=> card_oe_n_r && card_we_n_r && !card_io_r)
    else $error("card strobe outside areas 5 and 6");
  // An upper-half card address in area 6 is flagged as card I/O.
  chk_card_io_half: assert property (@(posedge ref_clk) disable iff (rst) // R15
    area_w == `BAWD_AREA6 && area6_card && io_half |=> card_io_r)
    else $error("card I/O half missed");
  // A high-lane card access in area 5 lowers card A's high enable and chip select 5.
  chk_card_hi_en: assert property (@(posedge ref_clk) disable iff (rst) // R18
    s_card_access ##0 (is_card5 && acc_bytes[1])
    |=> !card_a_high_byte_enable_n_r && !cs_n_r[`BAWD_AREA5])
    else $error("card high enable missing");
  // A card read lowers the card output enable, whatever the upper address bits.
  chk_card_rd_oe: assert property (@(posedge ref_clk) disable iff (rst) // R19 R17
    s_card_access ##0 acc_rd |=> !card_oe_n_r) else $error("card oe missing");
  // Once captured, the area 0 width never moves until the next reset.
  chk_strap_hold: assert property (@(posedge ref_clk) disable iff (rst) // R1
    state_r == bawd_pkg::BAWD_ST_RUN |=> $stable(area0_width_r))
    else $error("area 0 width changed after capture");
  // In big-endian mode the area 5 card I/O half keeps the configured width.
  chk_dyn_size_be: assert property (@(posedge ref_clk) disable iff (rst) // R16
    !little_endian && area_w == `BAWD_AREA5 && io_half && area5_card
    |=> width_r == $past(w5)) else $error("dynamic size in big-endian");
  // In little-endian mode the card I/O half follows the card's port report.
  chk_dyn_size_le: assert property (@(posedge ref_clk) disable iff (rst) // R16
    s_card_access ##0 (io_half && little_endian)
    |=> width_r == ($past(io_is16) ? `BAWD_W16 : `BAWD_W8))
    else $error("dynamic size in little-endian");
  // A card write lowers the write enable and leaves the output enable idle.
  chk_card_wr_we: assert property (@(posedge ref_clk) disable iff (rst) // R19
    s_card_access ##0 (acc_wr && !acc_rd) |=> !card_we_n_r && card_oe_n_r)
    else $error("card write strobe wrong");
  // A low-lane card access in area 6 lowers card B's low enable and not card A's.
  chk_card_lo_en: assert property (@(posedge ref_clk) disable iff (rst) // R19
    s_card_access ##0 (is_card6 && acc_bytes[0])
    |=> !card_b_low_byte_enable_n_r && card_a_low_byte_enable_n_r)
    else $error("card low enable wrong");
  // An area 0 access carries the width latched from the straps.
  chk_area0_width: assert property (@(posedge ref_clk) disable iff (rst) // R1
    s_area0_access |=> width_r == $past(area0_width_r))
    else $error("area 0 width not from straps");
  // An area 4 access carries the width from its configuration field.
  chk_cfg_width: assert property (@(posedge ref_clk) disable iff (rst) // R3
    area_w == `BAWD_AREA4 |=> width_r == $past(w4))
    else $error("area 4 width not from config");
  // On-chip accesses raise the internal select and no chip select.
  chk_internal_sel: assert property (@(posedge ref_clk) disable iff (rst) // R11
    s_internal_access |=> internal_sel_r && !ext_sel_r && cs_n_r == `BAWD_CSN_IDLE)
    else $error("internal access went external");

endmodule // bawd_top
`default_nettype wire

/* verification/bawd_card_model.sv */
// Card-side model that reports the width of the card's I/O port.
// Assumes the bench picks the card's port width through port16.
`default_nettype none
module bawd_card_model (
  input  wire logic port16,  // Card has a 16-bit I/O port.
  output logic      io_is16  // Width report seen by the decoder.
);
  timeunit 1ns;
  timeprecision 1ps;
  // The card only ever reports an 8-bit or a 16-bit port.
  assign io_is16 = port16;
endmodule // bawd_card_model
`default_nettype wire

/* verification/bawd_top_tb.sv */
// Bench for the area decoder: random accesses, expected results queued.
// Assumes bawd_top and the card model are compiled before it.
`default_nettype none
module bawd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst = 1'b1, p16 = 1'b0;  // Clock, reset, card port width.
  logic area0_width_strap_high = 1'b1, area0_width_strap_low = 1'b1;  // Straps.
  logic [13:0] area_width_config_reg = 14'h0;  // Per-area width codes.
  logic area5_card = 0, area6_card = 0, area2_sdram = 0, area3_sdram = 0;
  logic port_func_en = 0, little_endian = 0, acc_valid = 0, acc_rd = 0, acc_wr = 0;
  logic [31:0] phys_addr = 32'h0, x = 32'h37;  // Address and random state.
  logic [1:0] acc_bytes = 2'h0, width_r, area0_width_r;  // Lanes and widths.
  logic [2:0] area_r;  // Decoded area.
  logic [6:0] cs_n_r;  // Chip selects.
  logic ext_sel_r, internal_sel_r, card_io_r, card_oe_n_r, card_we_n_r, cfg_error_r, io_is16;
  logic card_a_low_byte_enable_n_r, card_a_high_byte_enable_n_r;
  logic card_b_low_byte_enable_n_r, card_b_high_byte_enable_n_r;
  logic [21:0] q[$];  // Expected results, oldest first.
  int n_errors = 0, total_checks = 0;
  // The design under test, every pin named.
  bawd_top u_dut (.ref_clk, .rst, .area0_width_strap_high, .area0_width_strap_low,
    .area_width_config_reg, .area5_card, .area6_card, .area2_sdram, .area3_sdram,
    .port_func_en, .little_endian, .io_is16, .phys_addr, .acc_valid, .acc_rd, .acc_wr,
    .acc_bytes, .area_r, .width_r, .ext_sel_r, .internal_sel_r, .cs_n_r, .card_io_r,
    .card_a_low_byte_enable_n_r, .card_a_high_byte_enable_n_r, .card_b_low_byte_enable_n_r,
    .card_b_high_byte_enable_n_r, .card_oe_n_r, .card_we_n_r, .area0_width_r, .cfg_error_r);
  // The card on the far side.
  bawd_card_model u_card (.port16(p16), .io_is16(io_is16));
  // Free-running bus clock.
  always #2 ref_clk = ~ref_clk;
  // Next value of the xorshift sequence.
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Counts a compare and reports a difference.
  task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic final_report();
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Works out the outputs that the present inputs must give one cycle later.
  function automatic logic [21:0] expv();
    logic [2:0] a;
    logic [1:0] w, w2, w3, w5, w6;
    logic [6:0] c;
    logic crd, ext, ca, cb, e;
    a = phys_addr[28:26];
    {w6, w5, w3, w2} = {area_width_config_reg[13:10], area_width_config_reg[7:4]};
    crd = (a == 3'h5 && area5_card) || (a == 3'h6 && area6_card);
    ext = acc_valid && a != 3'h1 && a != 3'h7;
    w = (a == 3'h0) ? {area0_width_strap_high, area0_width_strap_low} : 2'h0;
    if (a > 3'h0 && a < 3'h7) w = area_width_config_reg[2*a+:2];
    if (crd && phys_addr[25] && little_endian) w = p16 ? 2'h2 : 2'h1;
    c = 7'h7f;
    if (ext) c[a] = 1'b0;
    ca = acc_valid && a == 3'h5 && area5_card;
    cb = acc_valid && a == 3'h6 && area6_card;
    e = (area2_sdram && w2 == 2'h1) || (area3_sdram && w3 == 2'h1) ||
        (area5_card && w5 == 2'h3) || (area6_card && w6 == 2'h3) ||
        (area2_sdram && area3_sdram && w2 != w3) || (port_func_en && (w2 == 2'h3 || w3 == 2'h3));
    return {a, w, ext, acc_valid && !ext, c, crd && phys_addr[25], ~(ca && acc_bytes[0]),
            ~(ca && acc_bytes[1]), ~(cb && acc_bytes[0]), ~(cb && acc_bytes[1]),
            ~(acc_valid && crd && acc_rd), ~(acc_valid && crd && acc_wr), e};
  endfunction
  // Compares each result with the oldest note once the outputs have settled.
  always @(posedge ref_clk) if (q.size() > 0) begin
    #1 chk({area_r, width_r, ext_sel_r,
      internal_sel_r, cs_n_r, card_io_r, card_a_low_byte_enable_n_r,
      card_a_high_byte_enable_n_r, card_b_low_byte_enable_n_r, card_b_high_byte_enable_n_r,
      card_oe_n_r, card_we_n_r, cfg_error_r}, q.pop_front());
  end
  // Resets once per legal strap pattern, then drives random accesses.
  initial begin
    for (int s = 1; s < 4; s++) begin
      {area0_width_strap_high, area0_width_strap_low} = s[1:0];  // Never both low.
      rst = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk({13'h0, cs_n_r, area0_width_r}, {13'h0, 7'h7f, 2'h3});
      rst = 1'b0;
      @(negedge ref_clk);
      chk({20'h0, area0_width_r}, {20'h0, s[1:0]});
      repeat (300) begin
        x = xs(x);
        // Half the steps move only the upper bits; area 7 hits only probe the on-chip path.
        phys_addr = x[0] ? {x[31:29], phys_addr[28:0]} : x;
        x = xs(x);
        {area_width_config_reg, area5_card, area6_card, area2_sdram, area3_sdram,
         port_func_en, little_endian, p16, acc_valid, acc_rd, acc_wr, acc_bytes} = x[25:0];
        q.push_back(expv());
        @(negedge ref_clk);
      end
    end
    @(negedge ref_clk);
    final_report();
  end
  // Cuts a hang short well after the expected run of about 900 cycles.
  initial begin
    #20000;
    n_errors++;
    final_report();
  end
endmodule // bawd_top_tb
`default_nettype wire
